/* File: adcms_pkg.sv */
package adcms_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CFG,
		ST_CONV,
		ST_CAL,
		ST_POWER_DOWN_PIN_N
	} adcms_state_type;

	// Serial frame geometry, counted in serial clock rising edges
	localparam logic [5:0] EDGE_START    = 6'h00;
	localparam logic [5:0] EDGE_POL      = 6'h01;
	localparam logic [5:0] EDGE_CLKSEL   = 6'h02;
	localparam logic [5:0] EDGE_MODE_UP  = 6'h03;
	localparam logic [5:0] EDGE_MODE_LO  = 6'h04;
	localparam logic [5:0] EDGE_CFG_END  = 6'h07;
	localparam logic [5:0] PERIOD_SHORT  = 6'h18;
	localparam logic [5:0] PERIOD_LONG   = 6'h20;
	localparam logic [5:0] HOLD_SHORT    = 6'h06;
	localparam logic [5:0] HOLD_LONG     = 6'h0e;
	localparam logic [5:0] RESULT_LEAD   = 6'h11;
	localparam logic [5:0] ONE_EDGE      = 6'h01;
	localparam int         RESULT_W      = 16;

	// Mode codes (upper, lower)
	localparam logic [1:0] MODE_SHORT = 2'h0;
	localparam logic [1:0] MODE_CAL   = 2'h1;
	localparam logic [1:0] MODE_SWSD  = 2'h2;
	localparam logic [1:0] MODE_LONG  = 2'h3;

	// Calibration length in clocks
	localparam int CAL_CYCLES_DEF = 80000;
	localparam int CAL_CNT_W      = 17;

	// Register byte offsets
	localparam logic [4:0] OFS_CTRL     = 5'h00;
	localparam logic [4:0] OFS_STATUS   = 5'h04;
	localparam logic [4:0] OFS_RESULT   = 5'h08;
	localparam logic [4:0] OFS_CONFIG   = 5'h0c;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h14;

	// Field layout and reset values
	localparam int         CTRL_EN_BIT   = 0;
	localparam logic       CTRL_EN_RST   = 1'h1;
	localparam int         IRQ_W         = 4;
	localparam int         IRQ_CONV_DONE = 0;
	localparam int         IRQ_CAL_DONE  = 1;
	localparam int         IRQ_CAL_ABORT = 2;
	localparam int         IRQ_POWER_DOWN_PIN_N      = 3;
	localparam logic [3:0] IRQ_MASK_RST  = 4'h0;

endpackage

/* File: adcms_seq.sv */
`timescale 1ns/1ps

module adcms_seq #(
	parameter int CAL_CYCLES = adcms_pkg::CAL_CYCLES_DEF
) (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        ce,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             irq,
	// Serial pins, asynchronous to clk_sys
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        din,
	input  wire logic        rst_pin_n,
	input  wire logic        power_down_pin_n,
	output logic             dout,
	output logic             serial_strobe_out,
	// Converter core side, same clock
	input  wire logic [15:0] conv_raw,
	output logic             track_en,
	output logic             range_polarity_sel,
	output logic             cal_active,
	output logic             shutdown
);

	// Two-stage synchronisers plus one history stage for edges
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic       sclk_prev_q;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_n_s;
	logic       din_s;
	logic       rst_pin_n_s;
	logic       pd_pin_n_s;

	// Sequencer state
	adcms_pkg::adcms_state_type state_q;
	logic [5:0]  edge_cnt_q;       // Rising edges since start bit
	logic [7:0]  cfg_q;            // Configuration byte being shifted
	logic [1:0]  mode_q;           // Mode bits of this frame
	logic        intclk_q;         // Internal clock mode selected
	logic        last_long_q;      // Acquisition length of last conversion
	logic [15:0] shift_q;          // Outgoing result
	logic [15:0] result_q;         // Last coded result for software
	logic [adcms_pkg::CAL_CNT_W-1:0] cal_cnt_q; // Calibration ticks
	logic        start_bit;
	logic        long_sel;
	logic [5:0]  period;
	logic [5:0]  hold_edge;
	logic [15:0] coded;
	logic        cal_tick;

	// Register file
	logic        ctrl_en_q;
	logic [3:0]  irq_stat_q;
	logic [3:0]  irq_mask_q;
	logic [3:0]  irq_evt;
	logic        acc_go;
	logic        wr_go;

	localparam int CAL_CNT_W_L = adcms_pkg::CAL_CNT_W;
	localparam logic [CAL_CNT_W_L-1:0] CAL_LAST =
		CAL_CNT_W_L'(CAL_CYCLES - 1);

	// Synchronise every pin; stage one feeds only stage two
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sync1_q     <= 5'h1e;
			sync2_q     <= 5'h1e;
			sclk_prev_q <= 1'b0;
		end else if (ce) begin
			sync1_q     <= {power_down_pin_n, rst_pin_n, din, cs_n, sclk};
			sync2_q     <= sync1_q;
			sclk_prev_q <= sync2_q[0];
		end
	end

	assign sclk_rise   = sync2_q[0] & ~sclk_prev_q;
	assign sclk_fall   = ~sync2_q[0] & sclk_prev_q;
	assign cs_n_s      = sync2_q[1];
	assign din_s       = sync2_q[2];
	assign rst_pin_n_s = sync2_q[3];
	assign pd_pin_n_s  = sync2_q[4];

	// Start condition: selected, data high on a rising serial edge
	assign start_bit = sclk_rise & ~cs_n_s & din_s & ctrl_en_q;

	always_comb begin
		unique case (mode_q)
			adcms_pkg::MODE_LONG: long_sel = 1'b1;
			adcms_pkg::MODE_SWSD: long_sel = last_long_q;
			default:              long_sel = 1'b0;
		endcase
	end

	assign period    = long_sel ? adcms_pkg::PERIOD_LONG
				: adcms_pkg::PERIOD_SHORT;
	// hold on sixth or fourteenth falling edge
	assign hold_edge = long_sel ? adcms_pkg::HOLD_LONG
				: adcms_pkg::HOLD_SHORT;

	// core delivers offset binary; bipolar flips the sign bit
	assign coded = range_polarity_sel ? conv_raw
				: {~conv_raw[15], conv_raw[14:0]};

	// Calibration advances on clk_sys or on serial edges
	assign cal_tick = intclk_q ? 1'b1 : sclk_rise;

	// Main sequencer
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q    <= adcms_pkg::ST_IDLE;
			edge_cnt_q <= adcms_pkg::EDGE_START;
			cfg_q      <= 8'h00;
			mode_q     <= adcms_pkg::MODE_SHORT;
			cal_cnt_q  <= '0;
		end else if (ce) begin
			// pin reset or pin shutdown stops all
			if (!rst_pin_n_s || !pd_pin_n_s) begin
				state_q <= adcms_pkg::ST_IDLE;
			end else begin
				unique case (state_q)
					adcms_pkg::ST_IDLE,
					adcms_pkg::ST_POWER_DOWN_PIN_N,
					adcms_pkg::ST_CAL: begin
						// start bit wakes and begins a frame
						if (start_bit) begin
							state_q    <= adcms_pkg::ST_CFG;
							edge_cnt_q <= adcms_pkg::EDGE_START;
							cfg_q      <= 8'h01;
						end else if (state_q == adcms_pkg::ST_CAL &&
								cal_tick) begin
							if (cal_cnt_q == CAL_LAST)
								state_q <= adcms_pkg::ST_IDLE;
							cal_cnt_q <= cal_cnt_q + CAL_CNT_W_L'(1);
						end
					end
					adcms_pkg::ST_CFG: begin
						// Deselect mid-byte drops the frame
						if (cs_n_s) begin
							state_q <= adcms_pkg::ST_IDLE;
						end else if (sclk_rise) begin
							edge_cnt_q <= edge_cnt_q + adcms_pkg::ONE_EDGE;
							cfg_q      <= {cfg_q[6:0], din_s};
							if (edge_cnt_q + adcms_pkg::ONE_EDGE ==
									adcms_pkg::EDGE_MODE_LO)
								mode_q <= {cfg_q[0], din_s};
							if (edge_cnt_q + adcms_pkg::ONE_EDGE ==
									adcms_pkg::EDGE_CFG_END) begin
								if (mode_q == adcms_pkg::MODE_CAL) begin
									state_q   <= adcms_pkg::ST_CAL;
									cal_cnt_q <= '0;
								end else begin
									state_q <= adcms_pkg::ST_CONV;
								end
							end
						end
					end
					adcms_pkg::ST_CONV: begin
						if (cs_n_s) begin
							state_q <= adcms_pkg::ST_IDLE;
						end else if (sclk_rise) begin
							edge_cnt_q <= edge_cnt_q + adcms_pkg::ONE_EDGE;
							if (edge_cnt_q + adcms_pkg::ONE_EDGE ==
									period - adcms_pkg::ONE_EDGE) begin
								if (mode_q == adcms_pkg::MODE_SWSD)
									state_q <= adcms_pkg::ST_POWER_DOWN_PIN_N;
								else
									state_q <= adcms_pkg::ST_IDLE;
							end
						end
					end
					default: state_q <= adcms_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// Per-frame settings caught as their bits arrive
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			range_polarity_sel <= 1'b0;
			intclk_q           <= 1'b0;
			last_long_q        <= 1'b0;
		end else if (ce && state_q == adcms_pkg::ST_CFG && sclk_rise) begin
			// polarity takes effect on its own edge
			if (edge_cnt_q + adcms_pkg::ONE_EDGE == adcms_pkg::EDGE_POL)
				range_polarity_sel <= din_s;
			if (edge_cnt_q + adcms_pkg::ONE_EDGE == adcms_pkg::EDGE_CLKSEL)
				intclk_q <= din_s;
		end else if (ce && state_q == adcms_pkg::ST_CONV && sclk_rise &&
				edge_cnt_q + adcms_pkg::ONE_EDGE ==
				period - adcms_pkg::ONE_EDGE) begin
			// Remember length for a later shutdown conversion
			last_long_q <= long_sel;
		end
	end

	// track from first bit after start to hold edge
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			track_en <= 1'b0;
		end else if (ce) begin
			if (state_q != adcms_pkg::ST_CFG &&
					state_q != adcms_pkg::ST_CONV)
				track_en <= 1'b0;
			else if (sclk_rise && edge_cnt_q == adcms_pkg::EDGE_START)
				track_en <= 1'b1;
			else if (sclk_fall && edge_cnt_q == hold_edge)
				track_en <= 1'b0;
		end
	end

	// result leaves MSB first on falling edges
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			shift_q  <= 16'h0000;
			dout     <= 1'b0;
			result_q <= 16'h0000;
		end else if (ce) begin
			if (state_q != adcms_pkg::ST_CONV) begin
				dout <= 1'b0;
			end else if (sclk_fall &&
					edge_cnt_q == period - adcms_pkg::RESULT_LEAD) begin
				shift_q  <= {coded[14:0], 1'b0};
				dout     <= coded[15];
				result_q <= coded;
			end else if (sclk_fall &&
					edge_cnt_q > period - adcms_pkg::RESULT_LEAD) begin
				shift_q <= {shift_q[14:0], 1'b0};
				dout    <= shift_q[15];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			serial_strobe_out <= 1'b0;
			cal_active        <= 1'b0;
			shutdown          <= 1'b0;
		end else if (ce) begin
			if (state_q == adcms_pkg::ST_CAL)
				serial_strobe_out <= ~intclk_q;
			else
				serial_strobe_out <= intclk_q;
			cal_active <= (state_q == adcms_pkg::ST_CAL);
			shutdown   <= ~pd_pin_n_s | (state_q == adcms_pkg::ST_POWER_DOWN_PIN_N);
		end
	end

	// Events for the interrupt status
	always_comb begin
		irq_evt = 4'h0;
		irq_evt[adcms_pkg::IRQ_CONV_DONE] = state_q == adcms_pkg::ST_CONV &&
			sclk_rise && rst_pin_n_s && pd_pin_n_s && !cs_n_s &&
			edge_cnt_q + adcms_pkg::ONE_EDGE == period - adcms_pkg::ONE_EDGE;
		irq_evt[adcms_pkg::IRQ_CAL_DONE] = state_q == adcms_pkg::ST_CAL &&
			rst_pin_n_s && pd_pin_n_s && !start_bit && cal_tick &&
			cal_cnt_q == CAL_LAST;
		// abort by start, reset pin or shutdown pin
		irq_evt[adcms_pkg::IRQ_CAL_ABORT] = state_q == adcms_pkg::ST_CAL &&
			(start_bit || !rst_pin_n_s || !pd_pin_n_s);
		irq_evt[adcms_pkg::IRQ_POWER_DOWN_PIN_N] = irq_evt[adcms_pkg::IRQ_CONV_DONE] &&
			mode_q == adcms_pkg::MODE_SWSD;
	end

	// Bus handshake: one wait cycle, then one cycle with waitrequest low
	assign acc_go = (avs_read | avs_write) & avs_waitrequest;
	assign wr_go  = avs_write & ~avs_waitrequest;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else if (ce) begin
			avs_waitrequest <= ~acc_go;
			if (acc_go && avs_read) begin
				unique case (avs_address)
					adcms_pkg::OFS_CTRL:
						avs_readdata <= {31'h0, ctrl_en_q};
					adcms_pkg::OFS_STATUS:
						avs_readdata <= {26'h0, last_long_q,
							range_polarity_sel, intclk_q, shutdown,
							cal_active, state_q != adcms_pkg::ST_IDLE};
					adcms_pkg::OFS_RESULT:
						avs_readdata <= {16'h0, result_q};
					adcms_pkg::OFS_CONFIG:
						avs_readdata <= {24'h0, cfg_q};
					adcms_pkg::OFS_IRQ_STAT:
						avs_readdata <= {28'h0, irq_stat_q};
					adcms_pkg::OFS_IRQ_MASK:
						avs_readdata <= {28'h0, irq_mask_q};
					default:
						avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Control and mask registers
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl_en_q  <= adcms_pkg::CTRL_EN_RST;
			irq_mask_q <= adcms_pkg::IRQ_MASK_RST;
		end else if (ce && wr_go) begin
			if (avs_address == adcms_pkg::OFS_CTRL)
				ctrl_en_q <= avs_writedata[adcms_pkg::CTRL_EN_BIT];
			if (avs_address == adcms_pkg::OFS_IRQ_MASK)
				irq_mask_q <= avs_writedata[3:0];
		end
	end

	// Sticky status; a new event beats a same-cycle clear
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_stat_q <= 4'h0;
			irq        <= 1'b0;
		end else if (ce) begin
			if (wr_go && avs_address == adcms_pkg::OFS_IRQ_STAT)
				irq_stat_q <= (irq_stat_q & ~avs_writedata[3:0]) | irq_evt;
			else
				irq_stat_q <= irq_stat_q | irq_evt;
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

endmodule

/* File: adcms_props.sv */
`timescale 1ns/1ps
// Port-level checks on the mode sequencer
module adcms_props (
	input wire logic        clk_sys,
	input wire logic        srst,
	input wire logic        ce,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        irq,
	input wire logic        sclk,
	input wire logic        cs_n,
	input wire logic        din,
	input wire logic        rst_pin_n,
	input wire logic        power_down_pin_n,
	input wire logic        dout,
	input wire logic        serial_strobe_out,
	input wire logic [15:0] conv_raw,
	input wire logic        track_en,
	input wire logic        range_polarity_sel,
	input wire logic        cal_active,
	input wire logic        shutdown
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	// Bus answer comes one cycle after a taken request
	property p_ack_next; (avs_read || avs_write) && avs_waitrequest && ce
		|=> !avs_waitrequest; endproperty
	a_ack_next: assert property (p_ack_next) else $error("late answer");
	// Answer lasts one cycle only
	property p_ack_once; !avs_waitrequest && ce |=> avs_waitrequest;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("answer held");
	// Outputs come out of reset quiet
	property p_rst_vals; $past(srst) |-> !track_en && !cal_active
		&& !shutdown && !dout && !irq; endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset value");
	// Calibration never overlaps a tracking window
	property p_no_trk_cal; !(track_en && cal_active); endproperty
	a_no_trk_cal: assert property (p_no_trk_cal) else $error("overlap");
	// Pin shutdown shows within the synchroniser delay
	property p_pin_sd; !power_down_pin_n |-> ##[1:5] shutdown; endproperty
	a_pin_sd: assert property (p_pin_sd) else $error("no shutdown");
	// Falling shutdown pin stops calibration
	property p_pin_cal; $fell(power_down_pin_n) |-> ##[1:5] !cal_active;
	endproperty
	a_pin_cal: assert property (p_pin_cal) else $error("cal kept");
	// Reset pin stops calibration and tracking
	property p_rst_cal; !rst_pin_n |-> ##[1:5] (!cal_active && !track_en);
	endproperty
	a_rst_cal: assert property (p_rst_cal) else $error("not idle");
	// Deselected link leaves the data line low
	property p_cs_idle; cs_n [*8] |-> !dout && !track_en; endproperty
	a_cs_idle: assert property (p_cs_idle) else $error("dout busy");
	// Tracking only starts once awake
	property p_wake; $rose(track_en) |-> !shutdown; endproperty
	a_wake: assert property (p_wake) else $error("asleep");
	c_cal: cover property ($rose(cal_active));
	c_sd: cover property ($rose(shutdown));
	c_irq: cover property ($rose(irq));
endmodule

/* File: adcms_host.sv */
`timescale 1ns/1ps
// Serial host: clock stands still between frames
module adcms_host (
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din  = 1'b0;
	end
	task automatic frame(input logic [7:0] cfg, input int n,
		output logic [15:0] r);
		r = 16'h0000;
		// Odd offset keeps the link out of phase with clk_sys
		#13 cs_n = 1'b0;
		for (int k = 0; k < n; k++) begin
			din = (k < 8) ? cfg[7 - k] : ~din;
			#40 sclk = 1'b1;
			// Last sixteen rising edges carry the result
			if (k >= n - 16) r = {r[14:0], dout};
			#40 sclk = 1'b0;
		end
		#40 cs_n = 1'b1;
		// Released line must not keep its last value
		din = ~din;
	endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic        ce, avs_read, avs_write, rst_pin_n, power_down_pin_n;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [15:0] conv_raw, r;
	logic        avs_waitrequest, irq, sclk, cs_n, din, dout;
	logic        serial_strobe_out, track_en, range_polarity_sel;
	logic        cal_active, shutdown;
	int          err_count, checked, trk;
	int          exp_q[$];
	logic [3:0]  msk;

	always #5 clk_sys = ~clk_sys;
	// Tracking window length in system clocks
	always @(posedge clk_sys) if (track_en === 1'b1) trk <= trk + 1;

	adcms_seq #(.CAL_CYCLES(100)) dut (.clk_sys, .srst, .ce, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .irq, .sclk, .cs_n, .din, .rst_pin_n,
		.power_down_pin_n, .dout, .serial_strobe_out, .conv_raw,
		.track_en, .range_polarity_sel, .cal_active, .shutdown);
	adcms_host host (.sclk, .cs_n, .din, .dout);

	task conclude;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// Avalon access: hold until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk_sys);
			n++;
			if (n > 20) begin
				err_count++;
				conclude();
			end
		end while (avs_waitrequest !== 1'b0);
		// Read data stands at the edge that ends the wait
		v = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// Read until the bits in m are all set, within a bound
	task automatic poll(input logic [4:0] a, input logic [31:0] m,
		input string nm);
		logic [31:0] v;
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 32'h0, v);
			n++;
		end while ((v & m) !== m && n < 150);
		chk(nm, m, v & m);
		if ((v & m) !== m) conclude();
	endtask

	task automatic setmask(input logic [3:0] m);
		msk = m;
		bus(1'b1, adcms_pkg::OFS_IRQ_MASK, {28'h0, m}, q);
	endtask

	// Event bit: line follows mask, write one clears
	task automatic ack(input int b, input string nm);
		poll(adcms_pkg::OFS_IRQ_STAT, 32'h1 << b, nm);
		repeat (2) @(posedge clk_sys);
		chk("irq on", {31'h0, msk[b]}, {31'h0, irq});
		bus(1'b1, adcms_pkg::OFS_IRQ_STAT, 32'h1 << b, q);
		repeat (2) @(posedge clk_sys);
		chk("irq off", 32'h0, {31'h0, irq});
		bus(1'b0, adcms_pkg::OFS_IRQ_STAT, 32'h0, q);
		chk("w1c", 32'h0, q & (32'h1 << b));
	endtask

	// One conversion frame against the model queue
	task automatic conv(input logic pol, input logic [1:0] md, input int n);
		int e;
		@(posedge clk_sys);
		conv_raw <= 16'($urandom);
		@(posedge clk_sys);
		exp_q.push_back(pol ? conv_raw : conv_raw ^ 16'h8000);
		trk = 0;
		host.frame({1'b1, pol, 1'b1, md, 3'h0}, n, r);
		e = exp_q.pop_front();
		chk("result", e, {16'h0, r});
		chk("range", {31'h0, pol}, {31'h0, range_polarity_sel});
		chk("track", 1, trk >= n * 8 - 149 && trk <= n * 8 - 147);
		ack(0, "done");
		bus(1'b0, adcms_pkg::OFS_RESULT, 32'h0, q);
		chk("result reg", e, q);
	endtask

	initial begin
		void'($urandom(84135));
		ce = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		rst_pin_n = 1'b1;
		power_down_pin_n = 1'b1;
		conv_raw = 16'h0000;
		msk = 4'h0;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		// Register defaults and an unmapped place
		bus(1'b0, adcms_pkg::OFS_CTRL, 32'h0, q);
		chk("ctrl", 32'h1, q);
		bus(1'b0, adcms_pkg::OFS_IRQ_MASK, 32'h0, q);
		chk("mask", 32'h0, q);
		bus(1'b1, 5'h18, 32'hffffffff, q);
		bus(1'b0, 5'h18, 32'h0, q);
		chk("unmapped", 32'h0, q);
		// Serial enable off: a whole frame is ignored
		bus(1'b1, adcms_pkg::OFS_CTRL, 32'h0, q);
		host.frame(8'ha0, 24, r);
		bus(1'b0, adcms_pkg::OFS_STATUS, 32'h0, q);
		chk("ignored", 32'h0, q);
		bus(1'b1, adcms_pkg::OFS_CTRL, 32'h1, q);
		// Deselect mid-frame drops the conversion
		host.frame(8'ha0, 12, r);
		bus(1'b0, adcms_pkg::OFS_IRQ_STAT, 32'h0, q);
		chk("cut frame", 32'h0, q);
		$display("registers done");
		// Both ranges in short and long acquisition
		for (int i = 0; i < 4; i++) begin
			if (i == 2) setmask(4'h1);
			conv(i[0], i[1] ? adcms_pkg::MODE_LONG : adcms_pkg::MODE_SHORT,
				i[1] ? 32 : 24);
		end
		$display("conversions done");
		// Shutdown code repeats the last long length
		conv(1'b1, adcms_pkg::MODE_SWSD, 32);
		chk("sw sd", 32'h1, {31'h0, shutdown});
		ack(3, "sd event");
		// Start bit wakes; no recalibration needed
		conv(1'b0, adcms_pkg::MODE_SHORT, 24);
		chk("awake", 32'h0, {31'h0, shutdown});
		// Shutdown code after a short conversion stays short
		conv(1'b0, adcms_pkg::MODE_SWSD, 24);
		chk("sw sd short", 32'h1, {31'h0, shutdown});
		ack(3, "sd event short");
		$display("shutdown done");
		// Calibration: full run, four aborts, the last on external clock
		setmask(4'h2);
		for (int ab = 0; ab < 5; ab++) begin
			host.frame(ab == 4 ? 8'h88 : 8'ha8, 8, r);
			repeat (6) @(posedge clk_sys);
			chk("cal", 32'h1, {31'h0, cal_active});
			chk("strobe cal", {31'h0, ab == 4},
				{31'h0, serial_strobe_out});
			// Frozen clock enable holds the calibration count
			if (ab == 0) begin
				ce <= 1'b0;
				repeat (120) @(posedge clk_sys);
				ce <= 1'b1;
				chk("ce freeze", 32'h1, {31'h0, cal_active});
			end
			power_down_pin_n <= (ab != 1);
			rst_pin_n <= (ab != 2 && ab != 4);
			if (ab == 3) conv(1'b0, adcms_pkg::MODE_SHORT, 24);
			ack(ab == 0 ? 1 : 2, "cal end");
			chk("cal off", 32'h0, {31'h0, cal_active});
			chk("pin sd", {31'h0, ab == 1}, {31'h0, shutdown});
			power_down_pin_n <= 1'b1;
			rst_pin_n <= 1'b1;
			repeat (4) @(posedge clk_sys);
			chk("strobe idle", {31'h0, ab != 4},
				{31'h0, serial_strobe_out});
		end
		$display("calibration done");
		conclude();
	end
endmodule

bind adcms_seq adcms_props props_i (.clk_sys, .srst, .ce, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_readdata,
	.avs_waitrequest, .irq, .sclk, .cs_n, .din, .rst_pin_n,
	.power_down_pin_n, .dout, .serial_strobe_out, .conv_raw,
	.track_en, .range_polarity_sel, .cal_active, .shutdown);
